// ### bts_burst_sequencer.sv
// Burst transmit sequencer: wake, calibration, bit clock, bit capture,
// ramp timing and burst follow, plus hand-off of symbols to the core clock.
// Assumes link inputs are synchronous to the master clock, which runs free.
`timescale 1ns/10ps
`default_nettype none
module bts_burst_sequencer
  import bts_pkg::*;
#(
  parameter int CAL_PERIODS = CAL_DEFAULT_PERIODS // Calibration length
) (
  input  wire logic                   clk,            // Core clock
  input  wire logic                   rst,            // Async reset, high
  input  wire logic                   masterClk,      // Link master clock
  input  wire logic                   wakeIn,         // Wake, low sleeps
  input  wire logic                   burstRequest,   // Burst request
  input  wire logic                   serialTxBits,   // Serial data in
  output logic                        symbolBitClock, // Bit clock out
  output logic                        readyOut,       // Transmit ready
  output logic                        burstFollowOut, // Delayed request
  output logic                        envelopeUp,     // Envelope ramps up
  output logic      [SYMBOL_BITS-1:0] symbolData,     // Symbol, core side
  output logic                        symbolStrobe,   // New symbol pulse
  output logic                        burstActive     // Envelope, core side
);
  localparam int FOLLOW_N = FOLLOW_PIPE_PERIODS;

  bts_state_t             stateReg;
  bts_state_t             stateNext;
  logic [CAL_CNT_W-1:0]   calCnt_reg;
  logic [LEAD_CNT_W-1:0]  leadCnt_reg;
  logic [RAMP_CNT_W-1:0]  rampCnt_reg;
  logic                   bitRun;
  logic                   fallNow;
  logic                   bitSel_reg;
  logic                   firstBit_reg;
  logic [SYMBOL_BITS-1:0] symWord_reg;
  logic                   symToggle_reg;
  logic [FOLLOW_N-1:0]    followShift_reg;
  logic                   togSync;
  logic                   togSeen_reg;
  logic                   envSync;

  // ---------------- Master clock domain ----------------

  // Sequencing; wake low overrides every state
  always_comb begin
    stateNext = stateReg;
    if (!wakeIn) begin
      stateNext = ST_SLEEP;
    end else begin
      case (stateReg)
        ST_SLEEP: stateNext = ST_CAL;
        ST_CAL: begin
          if (calCnt_reg == CAL_CNT_W'(CAL_PERIODS - 1)) begin
            stateNext = ST_READY;
          end
        end
        ST_READY: begin
          if (burstRequest) begin
            stateNext = ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (leadCnt_reg == LEAD_LAST) begin
            stateNext = ST_RUN;
          end
        end
        ST_RUN: begin
          // The sender drops the request inside its window
          if (!burstRequest) begin
            stateNext = ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (rampCnt_reg == RAMP_LAST) begin
            stateNext = ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          // Stop only on a falling edge so no runt pulse escapes
          if (fallNow) begin
            stateNext = ST_READY;
          end
        end
        default: stateNext = ST_SLEEP;
      endcase
    end
  end

  // State register
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      stateReg <= ST_SLEEP;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Calibration timer, cleared outside calibration
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      calCnt_reg <= '0;
    end else if (stateReg == ST_CAL) begin
      calCnt_reg <= calCnt_reg + CAL_CNT_W'(1);
    end else begin
      calCnt_reg <= '0;
    end
  end

  // Lead timer from request to first bit clock rise
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      leadCnt_reg <= '0;
    end else if (stateReg == ST_LEAD) begin
      leadCnt_reg <= leadCnt_reg + LEAD_CNT_W'(1);
    end else begin
      leadCnt_reg <= '0;
    end
  end

  // Ramp-down timer, 7.5 bit clock periods of master cycles
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      rampCnt_reg <= '0;
    end else if (stateReg == ST_RAMP) begin
      rampCnt_reg <= rampCnt_reg + RAMP_CNT_W'(1);
    end else begin
      rampCnt_reg <= '0;
    end
  end

  // Ready follows the idle state; drops one edge after a request
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      readyOut <= 1'b0;
    end else begin
      readyOut <= (stateNext == ST_READY);
    end
  end

  // Envelope direction; it holds up from lead until the request drops
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      envelopeUp <= 1'b0;
    end else begin
      envelopeUp <= (stateNext == ST_LEAD) || (stateNext == ST_RUN);
    end
  end

  // Bit clock runs from the end of the lead until the drain completes
  assign bitRun = (stateReg == ST_RUN) || (stateReg == ST_RAMP) ||
                  (stateReg == ST_DRAIN);

  bts_bit_clock_div u_div (
    .masterClk (masterClk),
    .rst       (rst),
    .run       (bitRun),
    .clkOut    (symbolBitClock),
    .fallNow   (fallNow)
  );

  // Bit capture on falling edges while the burst is live; two bits a symbol
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      bitSel_reg   <= 1'b0;
      firstBit_reg <= 1'b0;
    end else if (stateReg != ST_RUN) begin
      bitSel_reg   <= 1'b0;
    end else if (fallNow) begin
      bitSel_reg   <= !bitSel_reg;
      firstBit_reg <= serialTxBits;
    end
  end

  // Completed symbol and its hand-off toggle; word holds for a symbol time
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      symWord_reg   <= '0;
      symToggle_reg <= 1'b0;
    end else if (stateReg == ST_RUN && fallNow && bitSel_reg) begin
      symWord_reg   <= {firstBit_reg, serialTxBits};
      symToggle_reg <= !symToggle_reg;
    end
  end

  // Burst follow: request delayed by the pipeline latency
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      followShift_reg <= '0;
    end else begin
      followShift_reg <= {followShift_reg[FOLLOW_N-2:0],
                          burstRequest};
    end
  end

  assign burstFollowOut = followShift_reg[FOLLOW_N-1];

  // ---------------- Core clock domain ----------------

  // Toggle and envelope level cross through two flops each
  bts_sync2 #(.WIDTH(2)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({symToggle_reg, envelopeUp}),
    .dout ({togSync, envSync})
  );

  // Word is stable for far longer than the toggle takes to arrive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      togSeen_reg  <= 1'b0;
      symbolStrobe <= 1'b0;
      symbolData   <= '0;
    end else begin
      togSeen_reg  <= togSync;
      symbolStrobe <= togSync ^ togSeen_reg;
      if (togSync ^ togSeen_reg) begin
        symbolData <= symWord_reg;
      end
    end
  end

  // Envelope level for the core side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burstActive <= 1'b0;
    end else begin
      burstActive <= envSync;
    end
  end

  // ---------------- Checks on the master clock ----------------

  default clocking cb @(posedge masterClk);
  endclocking
  default disable iff (rst);

  AST_CAL_BOUND: assert property (
    (stateReg == ST_CAL) |-> (calCnt_reg < CAL_CNT_W'(CAL_LIMIT_PERIODS)))
    else $error("calibration ran past its limit");

  AST_CAL_READY: assert property (
    (stateReg == ST_CAL && stateNext == ST_READY) |=> readyOut)
    else $error("ready did not rise when calibration ended");

  AST_LEAD_RISE: assert property (
    (stateReg == ST_READY && wakeIn && burstRequest) ##1 wakeIn[*3]
    |-> ##1 $rose(symbolBitClock))
    else $error("first bit clock rise not three periods after request");

  AST_CAPTURE: assert property (
    (stateReg == ST_RUN && fallNow && !bitSel_reg)
    |=> (firstBit_reg == $past(serialTxBits)))
    else $error("serial bit not captured on the falling edge");

  AST_HALF_HIGH: assert property (
    ($rose(symbolBitClock) && bitRun) ##1 bitRun[*8]
    |-> ##23 symbolBitClock ##1 !symbolBitClock)
    else $error("bit clock high time is not 32 periods");

  AST_RAMP_LEN: assert property (
    $fell(stateReg == ST_RAMP) && wakeIn
    |-> ($past(rampCnt_reg) == RAMP_LAST))
    else $error("ramp-down did not last 7.5 bit periods");

  AST_READY_END: assert property (
    (stateReg == ST_DRAIN && fallNow && wakeIn) |=> ##[0:29] readyOut)
    else $error("ready late after final bit clock fall");

  AST_ENV_DOWN: assert property (
    (stateReg == ST_RUN && !burstRequest) |=> !envelopeUp)
    else $error("envelope did not ramp down on request low");

  AST_FOLLOW: assert property (
    ##8 (burstFollowOut == $past(burstRequest, FOLLOW_N)))
    else $error("burst follow does not track the request");

  AST_SLEEP: assert property (
    !wakeIn |=> (stateReg == ST_SLEEP) && !readyOut ##1 !symbolBitClock)
    else $error("wake low did not put the section to sleep");

  // Between bursts the bit clock must rest low, or a runt edge would
  // clock a stray bit out of the controller
  AST_IDLE_CLOCK: assert property (
    (stateReg == ST_READY) |-> !symbolBitClock)
    else $error("bit clock not idle while ready");

  AST_READY_DROP: assert property (
    (stateReg == ST_READY && wakeIn && burstRequest)
    |=> !readyOut && envelopeUp)
    else $error("request did not start the ramp-up");

  AST_NO_LATE_BIT: assert property (
    (stateReg == ST_RAMP) |=> $stable(symToggle_reg))
    else $error("symbol captured after the request dropped");

  // Main scenarios reached by the bench
  COV_READY: cover property ($rose(readyOut));
  COV_BURST_START: cover property ($rose(symbolBitClock) && envelopeUp);
  COV_SYMBOL: cover property ($changed(symToggle_reg));
  COV_BURST_END: cover property (stateReg == ST_DRAIN && fallNow);
endmodule
`default_nettype wire

// ### bts_pkg.sv
// Constants, counts and state type for the burst transmit sequencer.
// Assumes a master clock near its nominal rate on the link side.
`default_nettype none
package bts_pkg;

  // Nominal rates; the divider is derived from them
  localparam int MCLK_NOMINAL_HZ  = 2688000;
  localparam int SYMBOL_RATE_HZ   = 42000;
  localparam int SYM_DIV_PERIODS  = MCLK_NOMINAL_HZ / SYMBOL_RATE_HZ;
  localparam int SYM_HALF_PERIODS = SYM_DIV_PERIODS / 2;
  localparam int SYM_PHASE_W      = 6;
  localparam logic [SYM_PHASE_W-1:0] SYM_PHASE_FALL =
    SYM_PHASE_W'(SYM_HALF_PERIODS);
  localparam logic [SYM_PHASE_W-1:0] SYM_PHASE_STEP = 6'h01;

  // Calibration: the limit is 4097 periods, we finish one period early
  localparam int CAL_LIMIT_PERIODS   = 4097;
  localparam int CAL_DEFAULT_PERIODS = CAL_LIMIT_PERIODS - 1;
  localparam int CAL_CNT_W           = 13;

  // Start-of-burst lead time to the first bit clock rise
  localparam int LEAD_PERIODS = 3;
  localparam int LEAD_CNT_W   = 2;
  localparam logic [LEAD_CNT_W-1:0] LEAD_LAST = LEAD_CNT_W'(LEAD_PERIODS - 2);

  // Ramp-down length in tenths of a bit clock period
  localparam int RAMP_TENTHS  = 75;
  localparam int RAMP_PERIODS = (RAMP_TENTHS * SYM_DIV_PERIODS) / 10;
  localparam int RAMP_CNT_W   = 9;
  localparam logic [RAMP_CNT_W-1:0] RAMP_LAST =
    RAMP_CNT_W'(RAMP_PERIODS - 1);

  // Limits that bind timing of the end of a burst
  localparam int READY_LIMIT_PERIODS = 30;
  localparam int BURST_END_SETUP     = 3;
  localparam int BURST_END_HOLD      = 124;

  // Pipeline latency mirrored on the burst follow output
  localparam int FOLLOW_PIPE_PERIODS = 8;

  // Bits per modulator symbol
  localparam int SYMBOL_BITS = 2;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_CAL,
    ST_READY,
    ST_LEAD,
    ST_RUN,
    ST_RAMP,
    ST_DRAIN
  } bts_state_t;

endpackage
`default_nettype wire

// ### bts_sync2.sv
// Two-stage level synchroniser.
// Assumes the input is a level that stays put for several destination clocks.
`timescale 1ns/10ps
`default_nettype none
module bts_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // Destination clock
  input  wire logic             rst,   // Async reset, high
  input  wire logic [WIDTH-1:0] din,   // Level from the other domain
  output logic      [WIDTH-1:0] dout   // Synchronised level
);
  logic [WIDTH-1:0] metaReg;

  // First stage is read only by the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      metaReg <= '0;
      dout    <= '0;
    end else begin
      metaReg <= din;
      dout    <= metaReg;
    end
  end
endmodule
`default_nettype wire

// ### bts_bit_clock_div.sv
// Symbol bit clock divider on the master clock.
// Assumes run stays high until the cycle after a falling edge.
`timescale 1ns/10ps
`default_nettype none
module bts_bit_clock_div
  import bts_pkg::*;
(
  input  wire logic masterClk, // Master clock
  input  wire logic rst,       // Async reset, high
  input  wire logic run,       // Clock runs while high
  output logic      clkOut,    // Symbol bit clock, from a flop
  output logic      fallNow    // This edge takes the clock low
);
  logic [SYM_PHASE_W-1:0] phaseReg;

  // Phase counts 64 periods; first half high, second half low
  always_ff @(posedge masterClk or posedge rst) begin
    if (rst) begin
      phaseReg <= '0;
      clkOut   <= 1'b0;
    end else if (!run) begin
      phaseReg <= '0;
      clkOut   <= 1'b0;
    end else begin
      phaseReg <= phaseReg + SYM_PHASE_STEP;
      clkOut   <= (phaseReg < SYM_PHASE_FALL);
    end
  end

  // Falling edge marker, used for bit capture and stopping
  assign fallNow = run && (phaseReg == SYM_PHASE_FALL);
endmodule
`default_nettype wire

// ### bts_ctrl_model.sv
// Baseband controller model: feeds the serial bits of one burst.
// Assumes the bit clock is launched from rising masterClk edges.
`timescale 1ns/10ps
`default_nettype none
module bts_ctrl_model (
  input  wire logic        masterClk,   // Link master clock
  input  wire logic        bitClk,      // Bit clock from the device
  input  wire logic [15:0] pattern,     // Bits to send, MSB first
  output logic             serialTxBits // Serial data to the device
);
  logic       bitClkOld;
  logic [4:0] idx;

  // New bit after each rise so it is steady across the next fall;
  // after the fall the hold is over, so the line shows the inverse
  always @(negedge masterClk) begin
    if (bitClk && !bitClkOld) begin
      serialTxBits <= (idx < 5'h10) ?
                      pattern[4'hF - idx[3:0]] : 1'b0;
      idx          <= idx + 5'h01;
    end else if (!bitClk && bitClkOld) begin
      serialTxBits <= ~serialTxBits;
    end
    bitClkOld <= bitClk;
  end

  // Idle line at time zero
  initial begin
    serialTxBits = 1'b0;
    bitClkOld    = 1'b0;
    idx          = 5'h00;
  end
endmodule
`default_nettype wire

// ### burst_transmit_sequencer_test.sv
// Testbench for the burst transmit sequencer: wake, one burst, sleep.
// Assumes the controller model and a free-running master clock.
`timescale 1ns/10ps
`default_nettype none
module burst_transmit_sequencer_test;
  import bts_pkg::*;
  localparam int CAL = 20; // Short calibration keeps the run brief
  typedef struct packed {
    logic [1:0] sendBits;
    logic [1:0] expSym;
  } bts_row_t;
  bts_row_t               rows [8];
  logic                   clk, rst, masterClk, wakeIn, burstRequest;
  logic                   serialTxBits, symbolBitClock, readyOut;
  logic                   burstFollowOut, envelopeUp, symbolStrobe;
  logic                   burstActive, bcOld, flOld;
  logic [SYMBOL_BITS-1:0] symbolData;
  logic [15:0]            pattern;
  logic [1:0]             gotSyms [$];
  int                     mismatches, totalChecks, edgeCount, fallCount;
  int                     lastFall, followRise, k, t0;

  bts_burst_sequencer #(.CAL_PERIODS(CAL)) u_dut (
    .clk(clk), .rst(rst), .masterClk(masterClk), .wakeIn(wakeIn),
    .burstRequest(burstRequest), .serialTxBits(serialTxBits),
    .symbolBitClock(symbolBitClock), .readyOut(readyOut),
    .burstFollowOut(burstFollowOut), .envelopeUp(envelopeUp),
    .symbolData(symbolData), .symbolStrobe(symbolStrobe),
    .burstActive(burstActive));
  bts_ctrl_model u_model (
    .masterClk(masterClk), .bitClk(symbolBitClock), .pattern(pattern),
    .serialTxBits(serialTxBits));

  // Core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Link clock, offset so its edges never line up with the core clock
  initial begin
    masterClk = 1'b0;
    #37;
    forever #80 masterClk = ~masterClk;
  end

  // Edge count and bit clock / follow edges seen once settled
  always @(posedge masterClk) edgeCount = edgeCount + 1;
  always @(negedge masterClk) begin
    if (!symbolBitClock && bcOld) begin
      fallCount = fallCount + 1;
      lastFall  = edgeCount;
    end
    if (burstFollowOut && !flOld) followRise = edgeCount;
    bcOld = symbolBitClock;
    flOld = burstFollowOut;
  end
  // Symbols handed to the core side
  always @(posedge clk) begin
    if (symbolStrobe === 1'b1) gotSyms.push_back(symbolData);
  end

  task automatic bad(input string msg);
    mismatches++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic check_bit(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) bad("flag");
  endtask
  task automatic check_int(input int got, input int lo, input int hi);
    totalChecks++;
    if (got < lo || got > hi) bad($sformatf("count %0d", got));
  endtask
  task automatic check_sym(input logic [1:0] got, input logic [1:0] exp);
    totalChecks++;
    if (got !== exp) bad("symbol");
  endtask
  // Link edges until a signal reaches a level, bounded
  task automatic count_until(ref logic sig, input logic lvl, output int n);
    n = 0;
    while (sig !== lvl && n < 2000) begin
      @(posedge masterClk);
      #1;
      n++;
    end
  endtask
  task automatic wake_check();
    @(negedge masterClk) wakeIn = 1'b1;
    count_until(readyOut, 1'b1, k);
    check_int(k, CAL + 1, CAL + 2);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, about twice the expected run
  initial begin
    #600000;
    mismatches++;
    give_verdict();
  end

  initial begin
    {rst, wakeIn, burstRequest, bcOld, flOld} = 5'h10;
    {mismatches, totalChecks, edgeCount, fallCount} = '0;
    {lastFall, followRise} = '0;
    rows = '{4'h0, 4'h5, 4'hA, 4'hF, 4'hF, 4'hA, 4'h5, 4'h0};
    foreach (rows[i]) pattern[15 - 2 * i -: 2] = rows[i].sendBits;
    repeat (5) @(negedge clk);
    check_bit(readyOut | symbolBitClock | envelopeUp, 1'b0);
    rst = 1'b0;
    // Request while asleep is ignored
    @(negedge masterClk) burstRequest = 1'b1;
    repeat (10) @(negedge masterClk);
    check_bit(envelopeUp | symbolBitClock | readyOut, 1'b0);
    burstRequest = 1'b0;
    repeat (10) @(negedge masterClk);
    wake_check();
    // Burst start and bit clock shape
    @(negedge masterClk) burstRequest = 1'b1;
    t0 = edgeCount + 1;
    count_until(symbolBitClock, 1'b1, k);
    check_int(k, LEAD_PERIODS + 1, LEAD_PERIODS + 1);
    check_bit(envelopeUp & ~readyOut, 1'b1);
    count_until(symbolBitClock, 1'b0, k);
    check_int(k, 32, 32);
    count_until(symbolBitClock, 1'b1, k);
    check_int(k, 32, 32);
    check_bit(burstActive, 1'b1);
    check_int(followRise - t0, 7, 8);
    // Drop the request just after the sixteenth bit
    k = 0;
    while (fallCount < 16 && k < 2000) begin
      @(posedge masterClk);
      k++;
    end
    @(negedge masterClk) burstRequest = 1'b0;
    t0 = edgeCount + 1;
    count_until(envelopeUp, 1'b0, k);
    check_int(k, 1, 1);
    count_until(readyOut, 1'b1, k);
    check_int(k, RAMP_PERIODS + 1, RAMP_PERIODS + SYM_DIV_PERIODS);
    @(negedge masterClk);
    #1;
    check_int(lastFall - t0, 480, 544);
    check_int(edgeCount - lastFall, 0, READY_LIMIT_PERIODS);
    repeat (20) @(posedge clk);
    check_bit(burstActive, 1'b0);
    check_int(gotSyms.size(), 8, 8);
    foreach (rows[i]) begin
      if (i < gotSyms.size()) begin
        check_sym(gotSyms[i], rows[i].expSym);
      end
    end
    // Sleep, then wake again to restart calibration
    @(negedge masterClk) wakeIn = 1'b0;
    count_until(readyOut, 1'b0, k);
    check_int(k, 1, 2);
    check_bit(symbolBitClock, 1'b0);
    wake_check();
    give_verdict();
  end
endmodule
`default_nettype wire
